// *** hw/pin_ctrl_defs.svh ***
// register offsets, field layouts and reset values of the pin controller
// assumes 32 lines maximum; included by the design and the bench
// Operation
// - ownership enable/disable registers with status readback
// - owned line forces peripheral input to default
// - output enable/disable registers, status readable
// - direction acts only under controller ownership
// - set/clear output level, status readable
// - owned non-output line is not driven
// - peripheral-owned line follows peripheral drive, direction
// - pin level always readable
// - glitch filter enable/disable with status
// - filter works under either ownership
// - irq enable/disable update readable mask
// - any level change sets status bit
// - irq asserted when masked status pending
// - status read returns flags then clears
// - all registers 32 bits, fixed bit mapping
// - missing lines ignore writes, read zero
// - open drain drives low only
// - open drain enable/disable/status, any ownership
// - slave selects bits 14, 21 default one
// - reset: all owned inputs except bit 25
// - per-line fixed default level table
// - one interrupt output per instance
`ifndef PIN_CTRL_DEFS_SVH
`define PIN_CTRL_DEFS_SVH

`define OFS_OWN_EN 8'h00
`define OFS_OWN_DIS 8'h04
`define OFS_OWN_STAT 8'h08
`define OFS_OUT_EN 8'h10
`define OFS_OUT_DIS 8'h14
`define OFS_OUT_STAT 8'h18
`define OFS_FLT_EN 8'h20
`define OFS_FLT_DIS 8'h24
`define OFS_FLT_STAT 8'h28
`define OFS_LVL_SET 8'h30
`define OFS_LVL_CLR 8'h34
`define OFS_LVL_STAT 8'h38
`define OFS_PIN_STAT 8'h3c
`define OFS_IRQ_EN 8'h40
`define OFS_IRQ_DIS 8'h44
`define OFS_IRQ_MASK 8'h48
`define OFS_IRQ_STAT 8'h4c
`define OFS_OD_EN 8'h50
`define OFS_OD_DIS 8'h54
`define OFS_OD_STAT 8'h58

`define LINES_EXIST 32'h3fffffff
`define OWN_RESET 32'h3dffffff
`define PERIPH_DEFAULT 32'h00204000
`define ZERO32 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define FILTER_LEN 2'h2

`endif

// *** hw/pin_ctrl_pkg.sv ***
// types shared by the pin controller and its bench
// assumes the constants header is included where numbers are needed
package pin_ctrl_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WRESP, BUS_RRESP} bus_state_t;
endpackage

// *** hw/parallel_io_pin_controller.sv ***
// per-line pin controller with axi4-lite register slave
// assumes pins are synchronous to sys_clk; one write or read at a time
`timescale 1ns/1ns
`include "pin_ctrl_defs.svh"

module parallel_io_pin_controller
    import pin_ctrl_pkg::*;
#(
    parameter logic [31:0] LINE_MASK = `LINES_EXIST,
    parameter logic [31:0] OWN_INIT = `OWN_RESET,
    parameter logic [31:0] OFF_LEVEL = `PERIPH_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pins
    input wire logic [31:0] pinIn,
    output logic [31:0] pinOut,
    output logic [31:0] pinOe,
    // peripheral side
    input wire logic [31:0] periphOut,
    input wire logic [31:0] periphOe,
    output logic [31:0] periphIn,
    // interrupt
    output logic changeIrq
);

    word_t ownStat, outStat, lvlStat, fltStat, irqMask, irqStat, odStat;
    word_t next_ownStat, next_outStat, next_lvlStat, next_fltStat;
    word_t next_irqMask, next_irqStat, next_odStat;
    word_t pinLevel, next_pinLevel, lastLevel, next_lastLevel;
    word_t fltPrev, next_fltPrev;
    logic [1:0] fltCnt [32];
    logic [1:0] next_fltCnt [32];
    word_t next_pinOut, next_pinOe, next_periphIn;
    logic next_changeIrq;
    bus_state_t state, next_state;
    logic haveAw, next_haveAw, haveW, next_haveW;
    logic [7:0] wAddr, next_wAddr;
    word_t wData, next_wData;
    logic wStrbAll, next_wStrbAll;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    word_t next_rdata;
    logic primed, next_primed;

    function automatic logic known_read(input logic [7:0] a);
        known_read = a inside {`OFS_OWN_STAT, `OFS_OUT_STAT, `OFS_FLT_STAT,
            `OFS_LVL_STAT, `OFS_PIN_STAT, `OFS_IRQ_MASK, `OFS_IRQ_STAT,
            `OFS_OD_STAT};
    endfunction

    function automatic logic known_write(input logic [7:0] a);
        known_write = a inside {`OFS_OWN_EN, `OFS_OWN_DIS, `OFS_OUT_EN,
            `OFS_OUT_DIS, `OFS_FLT_EN, `OFS_FLT_DIS, `OFS_LVL_SET,
            `OFS_LVL_CLR, `OFS_IRQ_EN, `OFS_IRQ_DIS, `OFS_OD_EN,
            `OFS_OD_DIS};
    endfunction

    // applies an enable/disable pair to a status word
    function automatic word_t set_clr(input word_t cur, input logic hit_en,
            input logic hit_dis, input word_t d);
        word_t m;
        m = d & LINE_MASK;
        set_clr = cur;
        if (hit_en) begin
            set_clr = cur | m;
        end
        if (hit_dis) begin
            set_clr = cur & ~m;
        end
    endfunction

    logic doWrite, doRead;
    assign doWrite = (state == BUS_IDLE) && haveAw && haveW;
    assign doRead = (state == BUS_IDLE) && !doWrite && arvalid && arready;

    // bus channel handling
    always_comb begin
        next_state = state;
        next_haveAw = haveAw;
        next_haveW = haveW;
        next_wAddr = wAddr;
        next_wData = wData;
        next_wStrbAll = wStrbAll;
        next_awready = awready;
        next_wready = wready;
        next_arready = arready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (awvalid && awready) begin
            next_haveAw = 1'b1;
            next_wAddr = awaddr;
            next_awready = 1'b0;
        end
        if (wvalid && wready) begin
            next_haveW = 1'b1;
            next_wData = wdata;
            next_wStrbAll = &wstrb;
            next_wready = 1'b0;
        end
        unique case (state)
            BUS_IDLE: begin
                if (doWrite) begin
                    next_state = BUS_WRESP;
                    next_bvalid = 1'b1;
                    next_bresp = known_write(wAddr) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
                    next_arready = 1'b0;
                end else if (doRead) begin
                    next_state = BUS_RRESP;
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rresp = known_read(araddr) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
                    unique case (araddr)
                        `OFS_OWN_STAT: next_rdata = ownStat;
                        `OFS_OUT_STAT: next_rdata = outStat;
                        `OFS_FLT_STAT: next_rdata = fltStat;
                        `OFS_LVL_STAT: next_rdata = lvlStat;
                        `OFS_PIN_STAT: next_rdata = pinLevel & LINE_MASK;
                        `OFS_IRQ_MASK: next_rdata = irqMask;
                        `OFS_IRQ_STAT: next_rdata = irqStat;
                        `OFS_OD_STAT: next_rdata = odStat;
                        default: next_rdata = `ZERO32;
                    endcase
                end
            end
            BUS_WRESP: begin
                if (bready) begin
                    next_bvalid = 1'b0;
                    next_haveAw = 1'b0;
                    next_haveW = 1'b0;
                    next_awready = 1'b1;
                    next_wready = 1'b1;
                    next_arready = 1'b1;
                    next_state = BUS_IDLE;
                end
            end
            BUS_RRESP: begin
                if (rready) begin
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                    next_state = BUS_IDLE;
                end
            end
        endcase
        // no read handshake while a complete write waits to be applied
        if (next_haveAw && next_haveW) begin
            next_arready = 1'b0;
        end
    end

    // configuration state and pin datapath
    always_comb begin
        logic wr;
        word_t change, d;
        wr = doWrite && wStrbAll;
        d = wData;
        next_ownStat = set_clr(ownStat, wr && wAddr == `OFS_OWN_EN,
            wr && wAddr == `OFS_OWN_DIS, d);
        next_outStat = set_clr(outStat, wr && wAddr == `OFS_OUT_EN,
            wr && wAddr == `OFS_OUT_DIS, d);
        next_fltStat = set_clr(fltStat, wr && wAddr == `OFS_FLT_EN,
            wr && wAddr == `OFS_FLT_DIS, d);
        next_lvlStat = set_clr(lvlStat, wr && wAddr == `OFS_LVL_SET,
            wr && wAddr == `OFS_LVL_CLR, d);
        next_irqMask = set_clr(irqMask, wr && wAddr == `OFS_IRQ_EN,
            wr && wAddr == `OFS_IRQ_DIS, d);
        next_odStat = set_clr(odStat, wr && wAddr == `OFS_OD_EN,
            wr && wAddr == `OFS_OD_DIS, d);
        // filter: level must hold four cycles before it is taken
        next_fltPrev = pinIn;
        next_pinLevel = pinLevel;
        for (int i = 0; i < 32; i++) begin
            next_fltCnt[i] = fltCnt[i];
            if (!fltStat[i]) begin
                next_pinLevel[i] = pinIn[i];
                next_fltCnt[i] = 2'h0;
            end else if (pinIn[i] != fltPrev[i]) begin
                next_fltCnt[i] = 2'h0;
            end else if (fltCnt[i] != `FILTER_LEN) begin
                next_fltCnt[i] = fltCnt[i] + 2'h1;
            end else begin
                next_pinLevel[i] = pinIn[i];
            end
        end
        // first sample after reset seeds the edge detector: no false change
        next_lastLevel = primed ? pinLevel : next_pinLevel;
        change = primed ? ((pinLevel ^ lastLevel) & LINE_MASK) : `ZERO32;
        next_primed = 1'b1;
        // set wins over the clear on read
        next_irqStat = ((doRead && araddr == `OFS_IRQ_STAT) ? `ZERO32
                                                            : irqStat)
            | change;
        next_changeIrq = |(next_irqStat & next_irqMask);
        next_periphIn = (ownStat & OFF_LEVEL)
            | (~ownStat & pinLevel);
        for (int i = 0; i < 32; i++) begin
            logic lvl, drv;
            lvl = ownStat[i] ? lvlStat[i] : periphOut[i];
            drv = ownStat[i] ? outStat[i] : periphOe[i];
            if (odStat[i]) begin
                drv = drv && !lvl;
            end
            next_pinOut[i] = odStat[i] ? 1'b0 : lvl;
            next_pinOe[i] = drv && LINE_MASK[i];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= BUS_IDLE;
            haveAw <= 1'b0;
            haveW <= 1'b0;
            wAddr <= 8'h00;
            wData <= `ZERO32;
            wStrbAll <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            arready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= `ZERO32;
            ownStat <= OWN_INIT;
            outStat <= `ZERO32;
            lvlStat <= `ZERO32;
            fltStat <= `ZERO32;
            irqMask <= `ZERO32;
            irqStat <= `ZERO32;
            odStat <= `ZERO32;
            pinLevel <= `ZERO32;
            lastLevel <= `ZERO32;
            fltPrev <= `ZERO32;
            for (int i = 0; i < 32; i++) begin
                fltCnt[i] <= 2'h0;
            end
            primed <= 1'b0;
            pinOut <= `ZERO32;
            pinOe <= `ZERO32;
            periphIn <= `ZERO32;
            changeIrq <= 1'b0;
        end else begin
            state <= next_state;
            haveAw <= next_haveAw;
            haveW <= next_haveW;
            wAddr <= next_wAddr;
            wData <= next_wData;
            wStrbAll <= next_wStrbAll;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            ownStat <= next_ownStat;
            outStat <= next_outStat;
            lvlStat <= next_lvlStat;
            fltStat <= next_fltStat;
            irqMask <= next_irqMask;
            irqStat <= next_irqStat;
            odStat <= next_odStat;
            pinLevel <= next_pinLevel;
            lastLevel <= next_lastLevel;
            fltPrev <= next_fltPrev;
            fltCnt <= next_fltCnt;
            primed <= next_primed;
            pinOut <= next_pinOut;
            pinOe <= next_pinOe;
            periphIn <= next_periphIn;
            changeIrq <= next_changeIrq;
        end
    end

    chk_owned_input_default: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ownStat[0] |=> periphIn[0] == 1'b0)
        else $error("owned line leaks pin to peripheral");
    chk_slave_select_default: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ownStat[14] && ownStat[21] |=> periphIn[14] && periphIn[21])
        else $error("slave select default not one");
    chk_undriven_input: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ownStat[3] && !outStat[3] |=> !pinOe[3])
        else $error("owned input line driven");
    chk_open_drain_high: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        pinOe[5] |-> !pinOut[5] || !$past(odStat[5]))
        else $error("open drain line drives high");
    chk_owned_level: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ownStat[7] && outStat[7] && !odStat[7]
        |=> pinOe[7] && pinOut[7] == $past(lvlStat[7]))
        else $error("owned output level wrong");
    chk_periph_follow: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !ownStat[25] && !odStat[25]
        |=> pinOut[25] == $past(periphOut[25]) &&
            pinOe[25] == $past(periphOe[25]))
        else $error("peripheral line not followed");
    chk_change_sets_flag: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        primed && pinLevel[1] != lastLevel[1] |=> irqStat[1])
        else $error("level change not flagged");
    chk_irq_output: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ##1 changeIrq == |(irqStat & irqMask))
        else $error("interrupt output mismatch");
    chk_missing_lines: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (ownStat[31:30] | outStat[31:30] | irqMask[31:30]) == 2'h0)
        else $error("missing line bits set");
    chk_status_read_clear: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        doRead && araddr == `OFS_IRQ_STAT && pinLevel == lastLevel
        ##1 pinLevel == lastLevel |=> irqStat == `ZERO32)
        else $error("status not cleared by read");
    cov_write: cover property (@(posedge sys_clk) bvalid && bready);
    cov_read: cover property (@(posedge sys_clk) rvalid && rready);
    cov_irq: cover property (@(posedge sys_clk) $rose(changeIrq));
    cov_od: cover property (@(posedge sys_clk) odStat[2] && pinOe[2]);

endmodule

// *** tb/pin_partner.sv ***
// board model for the pin controller: pull-ups and external drivers
// assumes each pin is a wired-and of the device and the board
`timescale 1ns/1ns

module pin_partner (
    // device side
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinOe,
    output logic [31:0] pinIn,
    // board side
    input wire logic [31:0] extLvl,
    input wire logic [31:0] extOe
);
    // a pin nobody pulls low reads high through its pull-up
    assign pinIn = (~pinOe | pinOut) & (~extOe | extLvl);
endmodule

// *** tb/test_parallel_io_pin_controller.sv ***
// self-checking bench of the pin controller: registers, pins, change irq
// assumes the board model stands for pull-ups and external drivers
`timescale 1ns/1ns
`include "pin_ctrl_defs.svh"

module test_parallel_io_pin_controller import pin_ctrl_pkg::*;;
    localparam word_t MASK = `LINES_EXIST;
    localparam logic [7:0] SA [7] = '{8'h00, 8'h14, 8'h24, 8'h34, 8'h44,
        8'h54, 8'h40};
    localparam word_t SD [7] = '{MASK, '1, '1, '1, '1, '1, 32'h8};
    logic sys_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, changeIrq;
    logic [7:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    word_t wdata, rdata, pinIn, pinOut, pinOe, periphOut, periphOe, periphIn;
    word_t extLvl, extOe, rd, eo, ev;
    word_t m [6];
    int nMismatch = 0;
    int checks = 0;

    parallel_io_pin_controller parallel_io_pin_controller_inst (
        .sys_clk(sys_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn),
        .changeIrq(changeIrq));
    pin_partner pin_partner_inst (.pinOut(pinOut), .pinOe(pinOe),
        .pinIn(pinIn), .extLvl(extLvl), .extOe(extOe));

    task automatic conclude();
        if (nMismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input word_t got, input word_t exp);
        checks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input word_t d,
        input logic [3:0] s);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic rd32(input logic [7:0] a, output word_t d);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        rs = rresp;
    endtask

    // expected drive enable and level of every pin from the model
    function automatic void expPins(output word_t oe, output word_t lv);
        lv = (m[0] & m[3]) | (~m[0] & periphOut);
        oe = (m[0] & m[1]) | (~m[0] & periphOe);
        oe = oe & ~(m[5] & lv);
        lv = lv & ~m[5];
    endfunction

    task automatic chkPins();
        word_t po;
        repeat (8) @(posedge sys_clk);
        expPins(eo, ev);
        po = (m[0] & `PERIPH_DEFAULT) | (~m[0] & pinIn);
        chk(pinOe & MASK, eo & MASK);
        chk(pinOut & eo & MASK, ev & eo & MASK);
        chk(periphIn & MASK, po & MASK);
        rd32(`OFS_PIN_STAT, rd);
        chk(rd, pinIn & MASK);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        #800000;
        nMismatch++;
        conclude();
    end

    initial begin
        int k;
        int r;
        word_t d;
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wstrb, wdata} = '0;
        {periphOut, periphOe, extLvl, extOe} = '0;
        void'($urandom(32'h32c6));
        m = '{default: '0};
        m[0] = `OWN_RESET;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        for (k = 0; k < 6; k++) begin
            rd32(8'(k * 16 + 8), rd);
            chk(rd, m[k] & MASK);
        end
        rd32(`OFS_IRQ_STAT, rd);
        chk(rd, 32'h0);
        chkPins();
        for (k = 0; k < 60; k++) begin
            r = $urandom_range(5);
            d = $urandom;
            periphOut <= $urandom;
            periphOe <= $urandom;
            extOe <= $urandom;
            extLvl <= $urandom;
            if ($urandom_range(1) == 1) begin
                wr(8'(r * 16), d, 4'hf);
                m[r] = m[r] | (d & MASK);
            end else begin
                wr(8'(r * 16 + 4), d, 4'hf);
                m[r] = m[r] & ~d;
            end
            chk(32'(rs), 32'(`RESP_OKAY));
            rd32(8'(r * 16 + 8), rd);
            chk(rd, m[r] & MASK);
            if (k % 4 == 0) chkPins();
        end
        wr(`OFS_OWN_DIS, '1, 4'h3);
        rd32(`OFS_OWN_STAT, rd);
        chk(rd, m[0] & MASK);
        rd32(8'h0c, rd);
        chk(32'(rs), 32'(`RESP_SLVERR));
        wr(8'h1c, '1, 4'hf);
        chk(32'(rs), 32'(`RESP_SLVERR));
        periphOe <= '0;
        extOe <= '0;
        for (k = 0; k < 7; k++) wr(SA[k], SD[k], 4'hf);
        repeat (8) @(posedge sys_clk);
        rd32(`OFS_IRQ_STAT, rd);
        repeat (2) @(posedge sys_clk);
        chk(32'(changeIrq), 32'h0);
        extOe <= 32'h28;
        extLvl <= '0;
        repeat (4) @(posedge sys_clk);
        chk(32'(changeIrq), 32'h1);
        rd32(`OFS_IRQ_STAT, rd);
        chk(rd, 32'h28);
        repeat (2) @(posedge sys_clk);
        chk(32'(changeIrq), 32'h0);
        rd32(`OFS_IRQ_STAT, rd);
        chk(rd, 32'h0);
        extLvl <= 32'h20;
        wr(`OFS_OUT_EN, 32'h80, 4'hf);
        repeat (4) @(posedge sys_clk);
        chk(32'(changeIrq), 32'h0);
        rd32(`OFS_IRQ_STAT, rd);
        chk(rd, 32'ha0);
        wr(`OFS_OWN_DIS, 32'h20, 4'hf);
        for (k = 0; k < 2; k++) begin
            wr(k == 0 ? `OFS_FLT_EN : `OFS_FLT_DIS, 32'h20, 4'hf);
            repeat (6) @(posedge sys_clk);
            rd32(`OFS_IRQ_STAT, rd);
            @(posedge sys_clk);
            extLvl <= 32'h0;
            @(posedge sys_clk);
            extLvl <= 32'h20;
            repeat (6) @(posedge sys_clk);
            chk(periphIn & 32'h20, 32'h20);
            rd32(`OFS_IRQ_STAT, rd);
            chk(rd, k == 0 ? 32'h0 : 32'h20);
        end
        conclude();
    end
endmodule
